// ===== design/cis_core.sv
// Width-switchable 16-bit instruction core with prefetch and stack
//
// Operation
// - Stack pointer left undefined by reset
// - Zero direct page low byte saves cycle
// - Decimal add: only carry flag updated
// - Decimal subtract: carry and zero updated
// - Only add and subtract use decimal
// - Flags m and x pick operand widths
// - Push/pull A,B,X,Y widths follow m and x
// - Pull A sets N,Z; multi-pull not
// - Push may save program bank; pull never
// - Block move count from A, zero none
// - Move addresses from X,Y, wrap by x
// - Break ignores its second byte
// - Long branch always lands in bank 0
// - Three-byte prefetch queue sets timing
// - Program fetch timing follows wait states
// - Even 16-bit data access is faster
module cis_core (
   input wire logic clk, // 125 MHz system clock
   input wire logic rst, // sync reset, active high
   output logic pm_req, // program fetch request
   output logic [23:0] pm_addr, // program fetch address
   input wire logic pm_ack, // program fetch done
   input wire logic [7:0] pm_rdata, // program byte
   output cis_pkg::cis_dmreq_s dm_o, // data and stack memory request
   input wire logic [15:0] dm_rdata, // data memory read data
   output cis_pkg::cis_regs_s regs_o, // architectural registers
   output logic instr_done // instruction completed
);
   import cis_pkg::*;

   cis_regs_s r_q;
   cis_regs_s r_d;
   cis_state_e st_q;
   cis_state_e st_d;
   cis_op_e op_q;
   cis_op_e op_d;
   logic [15:0] arg_q;
   logic [15:0] arg_d;
   logic [15:0] tmp_q;
   logic [15:0] tmp_d;
   logic [1:0] argn_q;
   logic [1:0] argn_d;
   logic [1:0] argi_q;
   logic [1:0] argi_d;
   logic [8:0] mask_q;
   logic [8:0] mask_d;
   logic hi_q;
   logic hi_d;
   logic done_q;
   logic done_d;
   cis_dmreq_s dm_q;
   cis_dmreq_s dm_d;
   logic pop;
   logic flush;
   logic [23:0] flush_addr;
   logic [7:0] q_head;
   logic q_valid;
   logic [15:0] val;

   cis_prefetch_q #(
      .DEPTH(QUEUE_DEPTH)
   ) u_queue (
      .clk(clk),
      .rst(rst),
      .flush(flush),
      .flush_addr(flush_addr),
      .pop(pop),
      .head(q_head),
      .head_valid(q_valid),
      .pm_req(pm_req),
      .pm_addr(pm_addr),
      .pm_ack(pm_ack),
      .pm_rdata(pm_rdata)
   );

   wire m8 = r_q.status[FLG_M];
   wire x8 = r_q.status[FLG_X];

   function automatic logic [1:0] arg_bytes(input logic [7:0] op, input logic m, input logic x);
      case (op)
         OP_LOAD_A, OP_LOAD_B, OP_ADD_CARRY, OP_SUB_BORROW, OP_AND: begin
            arg_bytes = m ? 2'h1 : 2'h2;
         end
         OP_LOAD_X, OP_LOAD_Y: begin
            arg_bytes = x ? 2'h1 : 2'h2;
         end
         OP_BRANCH_ALWAYS, OP_LOAD_DPAGE: arg_bytes = 2'h2;
         OP_LOAD_A_DIRECT, OP_MULTI_PUSH, OP_MULTI_PULL, OP_SOFT_BREAK: arg_bytes = 2'h1;
         OP_SET_FLAGS, OP_CLR_FLAGS: arg_bytes = 2'h1;
         default: arg_bytes = 2'h0;
      endcase
   endfunction

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nv,
                                         input logic narrow);
      return narrow ? {old[15:8], nv[7:0]} : nv;
   endfunction

   function automatic logic [15:0] fit(input logic [15:0] v, input logic narrow);
      return narrow ? {8'h00, v[7:0]} : v;
   endfunction

   function automatic logic [7:0] set_nz(input logic [7:0] st, input logic [15:0] v,
                                         input logic narrow);
      logic [7:0] r;
      r = st;
      r[FLG_N] = narrow ? v[7] : v[15];
      r[FLG_Z] = narrow ? (v[7:0] == 8'h00) : (v == 16'h0000);
      return r;
   endfunction

   function automatic logic [3:0] top_bit(input logic [8:0] msk);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 0; i < 9; i++) begin
         if (msk[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   function automatic logic [3:0] low_bit(input logic [8:0] msk);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 8; i >= 0; i--) begin
         if (msk[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   // Width of stacked A, B, X, Y follows the live m and x flags; D page and PC always wide, banks and status narrow
   function automatic logic reg_wide(input logic [3:0] idx, input logic m, input logic x);
      case (idx)
         4'(RB_A), 4'(RB_B): reg_wide = ~m;
         4'(RB_X), 4'(RB_Y): reg_wide = ~x;
         4'(RB_DPAGE), 4'(RB_PC): reg_wide = 1'b1;
         default: reg_wide = 1'b0;
      endcase
   endfunction

   function automatic logic [15:0] reg_val(input logic [3:0] idx, input cis_regs_s r);
      case (idx)
         4'(RB_A): reg_val = r.a;
         4'(RB_B): reg_val = r.b;
         4'(RB_X): reg_val = r.x;
         4'(RB_Y): reg_val = r.y;
         4'(RB_DPAGE): reg_val = r.dpage;
         4'(RB_DBANK): reg_val = {8'h00, r.dbank};
         4'(RB_PBANK): reg_val = {8'h00, r.pbank};
         4'(RB_STATUS): reg_val = {8'h00, r.status};
         default: reg_val = r.pc;
      endcase
   endfunction

   // Nibble adder chain; decimal correction only for add and subtract
   wire sub_w = (op_q == OP_SUB_BORROW);
   wire dec_w = r_q.status[FLG_D] & ((op_q == OP_ADD_CARRY) | sub_w);
   wire [15:0] alu_b = sub_w ? ~arg_q : arg_q;
   wire [4:0] nc;
   wire [15:0] sum;
   assign nc[0] = r_q.status[FLG_C];
   for (genvar g = 0; g < 4; g++) begin : g_nib
      wire [4:0] t = 5'(r_q.a[4*g+:4]) + 5'(alu_b[4*g+:4]) + 5'(nc[g]);
      wire adj = dec_w & (sub_w ? ~t[4] : (t > 5'h09));
      wire [4:0] tadj = sub_w ? (t - 5'h06) : (t + 5'h06);
      assign sum[4*g+:4] = adj ? tadj[3:0] : t[3:0];
      assign nc[g+1] = (dec_w & ~sub_w) ? adj : t[4];
   end
   wire alu_c = m8 ? nc[2] : nc[4];
   wire alu_sa = m8 ? r_q.a[7] : r_q.a[15];
   wire alu_sb = m8 ? alu_b[7] : alu_b[15];
   wire alu_sr = m8 ? sum[7] : sum[15];
   wire alu_v = (alu_sa == alu_sb) & (alu_sr != alu_sa);
   wire [7:0] bin_flags = set_nz(r_q.status, sum, m8);

   wire [15:0] dp_addr = r_q.dpage + {8'h00, arg_q[7:0]};
   wire dp_slow = (r_q.dpage[7:0] != 8'h00);
   wire [3:0] push_idx = top_bit(mask_q);
   wire [3:0] pull_idx = low_bit(mask_q);
   wire push_wide = reg_wide(push_idx, m8, x8);
   wire pull_wide = reg_wide(pull_idx, m8, x8);
   wire [15:0] push_val = reg_val(push_idx, r_q);
   wire [15:0] step = (op_q == OP_MOVE_FWD) ? 16'h0001 : 16'hFFFF;
   wire move_none = m8 ? (r_q.a[7:0] == 8'h00) : (r_q.a == 16'h0000);
   wire move_last = m8 ? (r_q.a[7:0] == 8'h01) : (r_q.a == 16'h0001);
   wire [15:0] br_target = r_q.pc + arg_q;

   always_comb begin
      r_d = r_q;
      st_d = st_q;
      op_d = op_q;
      arg_d = arg_q;
      tmp_d = tmp_q;
      argn_d = argn_q;
      argi_d = argi_q;
      mask_d = mask_q;
      hi_d = hi_q;
      done_d = 1'b0;
      dm_d = '0;
      pop = 1'b0;
      flush = 1'b0;
      flush_addr = {r_q.pbank, r_q.pc};
      val = 16'h0000;
      case (st_q)
         ST_OPCODE: begin
            if (q_valid) begin
               pop = 1'b1;
               op_d = cis_op_e'(q_head);
               arg_d = 16'h0000;
               argi_d = 2'h0;
               argn_d = arg_bytes(q_head, m8, x8);
               r_d.pc = r_q.pc + 16'h0001;
               st_d = (arg_bytes(q_head, m8, x8) == 2'h0) ? ST_EXEC : ST_ARG;
            end
         end
         ST_ARG: begin
            if (q_valid) begin
               pop = 1'b1;
               arg_d = (argi_q == 2'h0) ? {8'h00, q_head} : {q_head, arg_q[7:0]};
               argi_d = argi_q + 2'h1;
               r_d.pc = r_q.pc + 16'h0001;
               if (argi_q + 2'h1 == argn_q) begin
                  st_d = ST_EXEC;
               end
            end
         end
         ST_EXEC: begin
            st_d = ST_OPCODE;
            done_d = 1'b1;
            case (op_q)
               OP_LOAD_A: begin
                  r_d.a = merge(r_q.a, arg_q, m8);
                  r_d.status = set_nz(r_q.status, arg_q, m8);
               end
               OP_LOAD_B: begin
                  r_d.b = merge(r_q.b, arg_q, m8);
                  r_d.status = set_nz(r_q.status, arg_q, m8);
               end
               OP_LOAD_X: begin
                  r_d.x = fit(arg_q, x8);
                  r_d.status = set_nz(r_q.status, arg_q, x8);
               end
               OP_LOAD_Y: begin
                  r_d.y = fit(arg_q, x8);
                  r_d.status = set_nz(r_q.status, arg_q, x8);
               end
               OP_ADD_CARRY, OP_SUB_BORROW: begin
                  r_d.a = merge(r_q.a, sum, m8);
                  r_d.status[FLG_C] = alu_c;
                  if (!dec_w) begin
                     r_d.status = bin_flags;
                     r_d.status[FLG_C] = alu_c;
                     r_d.status[FLG_V] = alu_v;
                  end else if (sub_w) begin
                     r_d.status[FLG_Z] = bin_flags[FLG_Z];
                  end // Decimal add leaves Z, N, V untouched
               end
               OP_AND: begin
                  r_d.a = merge(r_q.a, r_q.a & arg_q, m8);
                  r_d.status = set_nz(r_q.status, r_q.a & arg_q, m8);
               end
               OP_LOAD_A_DIRECT: begin
                  tmp_d = dp_addr;
                  hi_d = 1'b0;
                  if (dp_slow) begin
                     st_d = ST_DP_ADJ;
                  end else begin
                     dm_d.req = 1'b1;
                     dm_d.wide = ~m8 & ~dp_addr[0];
                     dm_d.addr = {8'h00, dp_addr};
                     st_d = ST_READ;
                  end
                  done_d = 1'b0;
               end
               OP_MULTI_PUSH: begin
                  mask_d = {1'b0, arg_q[7:0]};
                  hi_d = 1'b0;
                  st_d = ST_PUSH;
                  done_d = 1'b0;
               end
               OP_MULTI_PULL, OP_PULL_A: begin
                  // Program bank can never be restored by a pull
                  mask_d = (op_q == OP_PULL_A) ? 9'h001 :
                           {1'b0, arg_q[7:0]} & ~(9'h001 << RB_PBANK);
                  hi_d = 1'b0;
                  st_d = ST_PULL;
                  done_d = 1'b0;
               end
               OP_MOVE_FWD, OP_MOVE_BACK: begin
                  if (!move_none) begin
                     st_d = ST_MOVE_RD;
                     done_d = 1'b0;
                  end
               end
               OP_SOFT_BREAK: begin
                  mask_d = BREAK_MASK; // Second byte never looked at
                  hi_d = 1'b0;
                  st_d = ST_PUSH;
                  done_d = 1'b0;
               end
               OP_BRANCH_ALWAYS: begin
                  r_d.pc = br_target;
                  r_d.pbank = 8'h00;
                  flush = 1'b1;
                  flush_addr = {8'h00, br_target};
               end
               OP_SET_FLAGS: r_d.status = r_q.status | arg_q[7:0];
               OP_CLR_FLAGS: r_d.status = r_q.status & ~arg_q[7:0];
               OP_X_TO_STACK: r_d.s = r_q.x;
               OP_LOAD_DPAGE: r_d.dpage = arg_q;
               default: ;
            endcase
         end
         ST_DP_ADJ: begin
            // Nonzero low byte costs the extra add cycle
            dm_d.req = 1'b1;
            dm_d.wide = ~m8 & ~tmp_q[0];
            dm_d.addr = {8'h00, tmp_q};
            st_d = ST_READ;
         end
         ST_READ: begin
            if (!dm_q.wide && !hi_q && !m8) begin
               // Odd address: second byte read costs one more cycle
               arg_d[7:0] = dm_rdata[7:0];
               hi_d = 1'b1;
               dm_d.req = 1'b1;
               dm_d.addr = {8'h00, tmp_q + 16'h0001};
            end else begin
               val = dm_q.wide ? dm_rdata :
                     (hi_q ? {dm_rdata[7:0], arg_q[7:0]} : {8'h00, dm_rdata[7:0]});
               r_d.a = merge(r_q.a, val, m8);
               r_d.status = set_nz(r_q.status, val, m8);
               hi_d = 1'b0;
               st_d = ST_OPCODE;
               done_d = 1'b1;
            end
         end
         ST_PUSH: begin
            if (mask_q == 9'h000) begin
               if (op_q == OP_SOFT_BREAK) begin
                  r_d.pc = BREAK_VECTOR;
                  r_d.pbank = 8'h00;
                  flush = 1'b1;
                  flush_addr = {8'h00, BREAK_VECTOR};
               end
               st_d = ST_OPCODE;
               done_d = 1'b1;
            end else begin
               dm_d.req = 1'b1;
               dm_d.we = 1'b1;
               dm_d.addr = {8'h00, r_q.s};
               dm_d.wdata = {8'h00,
                             (push_wide && !hi_q) ? push_val[15:8] : push_val[7:0]};
               r_d.s = r_q.s - 16'h0001;
               if (push_wide && !hi_q) begin
                  hi_d = 1'b1;
               end else begin
                  hi_d = 1'b0;
                  mask_d[push_idx] = 1'b0;
               end
            end
         end
         ST_PULL: begin
            if (mask_q == 9'h000) begin
               st_d = ST_OPCODE;
               done_d = 1'b1;
            end else begin
               dm_d.req = 1'b1;
               dm_d.addr = {8'h00, r_q.s + 16'h0001};
               r_d.s = r_q.s + 16'h0001;
               st_d = ST_PULL_CAP;
            end
         end
         ST_PULL_CAP: begin
            st_d = ST_PULL;
            if (pull_wide && !hi_q) begin
               tmp_d[7:0] = dm_rdata[7:0];
               hi_d = 1'b1;
            end else begin
               val = pull_wide ? {dm_rdata[7:0], tmp_q[7:0]} : {8'h00, dm_rdata[7:0]};
               hi_d = 1'b0;
               mask_d[pull_idx] = 1'b0;
               case (pull_idx)
                  4'(RB_A): r_d.a = merge(r_q.a, val, m8);
                  4'(RB_B): r_d.b = merge(r_q.b, val, m8);
                  4'(RB_X): r_d.x = fit(val, x8);
                  4'(RB_Y): r_d.y = fit(val, x8);
                  4'(RB_DPAGE): r_d.dpage = val;
                  4'(RB_DBANK): r_d.dbank = val[7:0];
                  4'(RB_STATUS): r_d.status = val[7:0];
                  default: ;
               endcase
               if (op_q == OP_PULL_A) begin
                  r_d.status = set_nz(r_q.status, val, m8);
               end
            end
         end
         ST_MOVE_RD: begin
            dm_d.req = 1'b1;
            dm_d.addr = {r_q.dbank, r_q.x};
            st_d = ST_MOVE_WR;
         end
         ST_MOVE_WR: begin
            dm_d.req = 1'b1;
            dm_d.we = 1'b1;
            dm_d.addr = {r_q.dbank, r_q.y};
            dm_d.wdata = {8'h00, dm_rdata[7:0]};
            r_d.x = fit(r_q.x + step, x8);
            r_d.y = fit(r_q.y + step, x8);
            r_d.a = merge(r_q.a, r_q.a - 16'h0001, m8);
            if (move_last) begin
               st_d = ST_OPCODE;
               done_d = 1'b1;
            end else begin
               st_d = ST_MOVE_RD;
            end
         end
         default: st_d = ST_OPCODE;
      endcase
      if (r_d.status[FLG_X]) begin
         r_d.x[15:8] = 8'h00;
         r_d.y[15:8] = 8'h00;
      end
      if (rst) begin
         r_d = '0;
         r_d.s = r_q.s; // No reset value for the stack pointer
         r_d.pc = RESET_PC;
         r_d.status = STATUS_RESET;
         st_d = ST_OPCODE;
         op_d = OP_NOP;
         arg_d = 16'h0000;
         tmp_d = 16'h0000;
         argn_d = 2'h0;
         argi_d = 2'h0;
         mask_d = 9'h000;
         hi_d = 1'b0;
         done_d = 1'b0;
         dm_d = '0;
         pop = 1'b0;
         flush = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      r_q <= r_d;
      st_q <= st_d;
      op_q <= op_d;
      arg_q <= arg_d;
      tmp_q <= tmp_d;
      argn_q <= argn_d;
      argi_q <= argi_d;
      mask_q <= mask_d;
      hi_q <= hi_d;
      done_q <= done_d;
      dm_q <= dm_d;
   end

   assign dm_o = dm_q;
   assign regs_o = r_q;
   assign instr_done = done_q;

endmodule

// ===== design/cis_pkg.sv
// Shared constants, encodings and carrier types of the instruction core
package cis_pkg;

   // Prefetch queue and vectors
   localparam int unsigned QUEUE_DEPTH = 3;
   localparam logic [15:0] RESET_PC = 16'h0000;
   localparam logic [15:0] BREAK_VECTOR = 16'hFFF0;

   // Status register bit positions
   localparam int unsigned FLG_C = 0;
   localparam int unsigned FLG_Z = 1;
   localparam int unsigned FLG_I = 2;
   localparam int unsigned FLG_D = 3;
   localparam int unsigned FLG_X = 4;
   localparam int unsigned FLG_M = 5;
   localparam int unsigned FLG_V = 6;
   localparam int unsigned FLG_N = 7;
   localparam logic [7:0] STATUS_RESET = 8'h34;

   // Register select bits of the push and pull masks; the operand sets bits 0 to 7, only break sets PC bit 8
   localparam int unsigned RB_A = 0;
   localparam int unsigned RB_B = 1;
   localparam int unsigned RB_X = 2;
   localparam int unsigned RB_Y = 3;
   localparam int unsigned RB_DPAGE = 4;
   localparam int unsigned RB_DBANK = 5;
   localparam int unsigned RB_PBANK = 6;
   localparam int unsigned RB_STATUS = 7;
   localparam int unsigned RB_PC = 8;
   localparam logic [8:0] BREAK_MASK = 9'h140;

   typedef enum logic [7:0] {
      OP_NOP           = 8'h00,
      OP_LOAD_A        = 8'h01,
      OP_LOAD_X        = 8'h02,
      OP_LOAD_Y        = 8'h03,
      OP_ADD_CARRY     = 8'h04,
      OP_SUB_BORROW    = 8'h05,
      OP_AND           = 8'h06,
      OP_LOAD_A_DIRECT = 8'h07,
      OP_MULTI_PUSH    = 8'h08,
      OP_MULTI_PULL    = 8'h09,
      OP_PULL_A        = 8'h0A,
      OP_MOVE_FWD      = 8'h0B,
      OP_SOFT_BREAK    = 8'h0C,
      OP_BRANCH_ALWAYS = 8'h0D,
      OP_SET_FLAGS     = 8'h0E,
      OP_CLR_FLAGS     = 8'h0F,
      OP_X_TO_STACK    = 8'h10,
      OP_LOAD_DPAGE    = 8'h11,
      OP_LOAD_B        = 8'h13,
      OP_MOVE_BACK     = 8'h14
   } cis_op_e;

   typedef enum logic [3:0] {
      ST_OPCODE   = 4'h0,
      ST_ARG      = 4'h1,
      ST_EXEC     = 4'h2,
      ST_DP_ADJ   = 4'h3,
      ST_READ     = 4'h4,
      ST_PUSH     = 4'h5,
      ST_PULL     = 4'h6,
      ST_PULL_CAP = 4'h7,
      ST_MOVE_RD  = 4'h8,
      ST_MOVE_WR  = 4'h9
   } cis_state_e;

   typedef struct packed {
      logic        req;
      logic        we;
      logic        wide;
      logic [23:0] addr;
      logic [15:0] wdata;
   } cis_dmreq_s;

   typedef struct packed {
      logic [15:0] a;
      logic [15:0] b;
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] s;
      logic [15:0] dpage;
      logic [15:0] pc;
      logic [7:0]  pbank;
      logic [7:0]  dbank;
      logic [7:0]  status;
   } cis_regs_s;

endpackage

// ===== design/cis_prefetch_q.sv
// Instruction prefetch queue feeding the core from program memory
module cis_prefetch_q #(
   parameter int unsigned DEPTH = cis_pkg::QUEUE_DEPTH
) (
   input wire logic clk, // system clock
   input wire logic rst, // sync reset, active high
   input wire logic flush, // drop queued bytes, restart fetch
   input wire logic [23:0] flush_addr, // restart address
   input wire logic pop, // core consumes head byte
   output logic [7:0] head, // oldest queued byte
   output logic head_valid, // queue holds a byte
   output logic pm_req, // fetch request
   output logic [23:0] pm_addr, // fetch address
   input wire logic pm_ack, // fetch done, byte valid
   input wire logic [7:0] pm_rdata // fetched byte
);
   import cis_pkg::*;

   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);

   logic [7:0] mem_q [DEPTH];
   logic [PW-1:0] rd_q;
   logic [PW-1:0] wr_q;
   logic [CW-1:0] cnt_q;
   logic [23:0] fa_q;

   wire push = pm_req & pm_ack;
   wire take = pop & head_valid;

   function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
      return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   assign head_valid = (cnt_q != '0);
   assign head = mem_q[rd_q];
   // Fetch runs ahead whenever a slot is free; wait states only stretch pm_ack
   assign pm_req = ~flush & (cnt_q != CW'(DEPTH));
   assign pm_addr = fa_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_q <= '0;
         wr_q <= '0;
         cnt_q <= '0;
         fa_q <= {8'h00, RESET_PC};
      end else if (flush) begin
         rd_q <= '0;
         wr_q <= '0;
         cnt_q <= '0;
         fa_q <= flush_addr;
      end else begin
         if (push) begin
            wr_q <= nxt(wr_q);
            fa_q <= {fa_q[23:16], fa_q[15:0] + 16'h0001};
         end
         if (take) begin
            rd_q <= nxt(rd_q);
         end
         cnt_q <= cnt_q + CW'(push) - CW'(take);
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= pm_rdata;
      end
   end

endmodule

// ===== verif/cis_mem_model.sv
// Program and data memory model on the far side of the core
module cis_mem_model (
   input wire logic clk, // clock
   input wire logic slow, // fetch wait states on
   input wire logic pm_req, // fetch request
   input wire logic [23:0] pm_addr, // fetch address
   output logic pm_ack, // fetch done
   output logic [7:0] pm_rdata, // fetched byte
   input wire cis_pkg::cis_dmreq_s dm_o, // data request
   output logic [15:0] dm_rdata // read data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] pm [0:65535];
   logic [7:0] dm [0:65535];
   logic tg = 1'b0;
   wire [15:0] da = dm_o.addr[15:0];
   wire rd = dm_o.req && !dm_o.we;
   always @(posedge clk) begin
      tg <= ~tg;
      if (dm_o.req && dm_o.we) dm[da] <= dm_o.wdata[7:0];
   end
   // Slow mode answers every other cycle only
   assign pm_ack = pm_req && (!slow || tg);
   // Idle lines toggle so a stale byte never passes
   assign pm_rdata = pm_ack ? pm[pm_addr[15:0]] : {8{tg}};
   assign dm_rdata = !rd ? {16{tg}} :
      dm_o.wide ? {dm[da + 16'h1], dm[da]} : {{8{tg}}, dm[da]};
endmodule

// ===== verif/cis_core_monitor.sv
// Port checker for the core, bound below
module cis_core_monitor (
   input wire logic clk, // clock
   input wire logic rst, // sync reset
   input wire logic pm_req, // fetch request
   input wire logic [23:0] pm_addr, // fetch address
   input wire logic pm_ack, // fetch done
   input wire cis_pkg::cis_dmreq_s dm_o, // data request
   input wire cis_pkg::cis_regs_s regs_o // registers
);
   timeunit 1ns;
   timeprecision 1ps;
   import cis_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_fetch; pm_req && pm_ack; endsequence
   sequence s_next; !pm_req || pm_addr[15:0] == $past(pm_addr[15:0]) + 16'h1; endsequence
   a_reset_status: assert property ($fell(rst) |-> regs_o.status == STATUS_RESET)
      else $error("status not at reset value");
   a_fetch_seq: assert property (s_fetch |=> s_next)
      else $error("fetch address not sequential");
   a_fetch_hold: assert property (pm_req && !pm_ack |=> !pm_req || $stable(pm_addr))
      else $error("fetch address moved in wait");
   a_fetch_bank: assert property (pm_req |-> pm_addr[23:16] == 8'h00)
      else $error("fetch outside bank zero");
   a_x_upper: assert property (regs_o.status[FLG_X] && $past(regs_o.status[FLG_X])
      |-> regs_o.x[15:8] == 8'h00 && regs_o.y[15:8] == 8'h00)
      else $error("index upper byte set");
   a_narrow_ahi: assert property (!$past(rst) && regs_o.status[FLG_M]
      && $past(regs_o.status[FLG_M]) |-> $stable(regs_o.a[15:8]))
      else $error("upper byte of A changed");
   a_pbank_zero: assert property ($changed(regs_o.pbank) |-> regs_o.pbank == 8'h00)
      else $error("program bank restored");
   a_wide_even: assert property (dm_o.req && dm_o.wide |-> !dm_o.we && !dm_o.addr[0])
      else $error("wide access at odd address");
endmodule
bind cis_core cis_core_monitor i_cis_core_monitor (.clk(clk), .rst(rst), .pm_req(pm_req),
   .pm_addr(pm_addr), .pm_ack(pm_ack), .dm_o(dm_o), .regs_o(regs_o));

// ===== verif/cis_core_tb_top.sv
// Bench running a short program through the core
`define CK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch %0t got %0h want %0h", $time, (g), (e)); end end
`define M(a) i_cis_mem_model.dm[a]
module cis_core_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import cis_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic slow = 1'b0;
   logic pm_req, pm_ack, instr_done;
   logic [23:0] pm_addr;
   logic [7:0] pm_rdata;
   logic [15:0] dm_rdata;
   cis_dmreq_s dm_o;
   cis_regs_s regs_o;
   int n_mismatch = 0;
   int cmp_count = 0;
   int nd = 0;
   time td = 0;
   time tl, t0, t1;
   logic [31:0] ra, rb, rc, rk;
   byte unsigned p[$];
   initial forever #4 clk = ~clk;
   cis_core i_cis_core (.clk(clk), .rst(rst), .pm_req(pm_req), .pm_addr(pm_addr),
      .pm_ack(pm_ack), .pm_rdata(pm_rdata), .dm_o(dm_o), .dm_rdata(dm_rdata),
      .regs_o(regs_o), .instr_done(instr_done));
   cis_mem_model i_cis_mem_model (.clk(clk), .slow(slow), .pm_req(pm_req),
      .pm_addr(pm_addr), .pm_ack(pm_ack), .pm_rdata(pm_rdata), .dm_o(dm_o),
      .dm_rdata(dm_rdata));
   task automatic upto(input int k);
      while (nd < k) begin
         @(negedge clk);
         if (instr_done === 1'b1) begin
            nd++;
            tl = $time - td;
            td = $time;
         end
      end
      $display("test %0d done", k);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #100us;
      n_mismatch++;
      finish_test();
   end
   initial begin
      void'($urandom(9503));
      ra = $urandom_range(16'hFFFF, 1);
      rb = $urandom_range(8'hFF, 1);
      rc = $urandom;
      rk = $urandom;
      // Banks never loaded, so both stay zero
      p = {8'h0F, 8'h30, 8'h01, ra[7:0], ra[15:8], 8'h0E, 8'h20, 8'h01, rb[7:0], 8'h01,
         8'h99, 8'h0E, 8'h08, 8'h0F, 8'h01, 8'h04, 8'h01, 8'h0F, 8'h08, 8'h02, 8'h00, 8'h02,
         8'h10, 8'h08, 8'h41, 8'h01, 8'h5A, 8'h09, 8'h41, 8'h0A, 8'h0E, 8'h10, 8'h02, 8'hFE,
         8'h03, 8'h10, 8'h01, 8'h03, 8'h0B, 8'h01, 8'h00, 8'h0B, 8'h0C, rk[7:0]};
      for (int i = 0; i < 65536; i++) i_cis_mem_model.pm[i] = 8'h00;
      foreach (p[i]) i_cis_mem_model.pm[i] = p[i];
      // Break vector branches back into bank 0 across the 16-bit wrap
      p = {8'h0D, 8'h0D, 8'h01};
      foreach (p[i]) i_cis_mem_model.pm[16'hFFF0 + i] = p[i];
      p = {8'h0E, 8'h08, 8'h05, 8'h01, 8'h0F, 8'h28, 8'h07, 8'h10, 8'h11, 8'h02, 8'h00,
         8'h07, 8'h0E, 8'h07, 8'h0F};
      foreach (p[i]) i_cis_mem_model.pm[16'h0100 + i] = p[i];
      `M(16'h01FF) = 8'hFF;
      `M(16'h0200) = 8'hFF;
      {`M(16'h0000), `M(16'h00FF), `M(16'h00FE)} = rc[23:0];
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      upto(2);
      `CK(regs_o.a, ra[15:0])
      upto(4);
      `CK(regs_o.a, {ra[15:8], rb[7:0]})
      upto(8);
      `CK(regs_o.a[7:0], 8'h00)
      `CK({regs_o.status[FLG_C], regs_o.status[FLG_Z]}, 2'b10)
      @(posedge clk) slow <= 1'b1;
      upto(12);
      `CK({regs_o.s, `M(16'h0200), `M(16'h01FF)}, 32'h01FE0000)
      upto(14);
      `CK({regs_o.a, regs_o.s}, {ra[15:8], 24'h0001FF})
      `CK(regs_o.status[FLG_Z], 1'b0)
      upto(15);
      `CK({regs_o.status[FLG_Z], regs_o.s}, 17'h10200)
      upto(20);
      `CK({regs_o.x, regs_o.y}, 32'h00010013)
      // Last write of the move lands one edge after its done pulse
      upto(21);
      `CK({`M(16'h0012), `M(16'h0011), `M(16'h0010)}, rc[23:0])
      upto(22);
      `CK(regs_o.x, 16'h0001)
      upto(23);
      `CK({regs_o.pc, regs_o.s}, {BREAK_VECTOR, 16'h01FD})
      @(posedge clk) slow <= 1'b0;
      upto(24);
      `CK({regs_o.pbank, regs_o.pc}, 24'h000100)
      upto(26);
      `CK({regs_o.a[7:0], regs_o.status & 8'h83}, 16'h9900)
      upto(28);
      `CK(regs_o.a, rc[15:0])
      t0 = tl;
      upto(30);
      `CK({regs_o.a, tl}, {rc[15:0], t0 + 64'd8})
      t1 = tl;
      upto(31);
      `CK({regs_o.a, tl > t1}, {rc[23:8], 1'b1})
      finish_test();
   end
endmodule
